/* touch_adc_pkg.sv */
/*
  Constants shared by the touch-screen converter control block: register
  addresses and field positions, reset values, function codes, result
  slots, state codes and timing counts.
  Assumes a 100 MHz core clock.
*/
package touch_adc_pkg;

  // ****************************************
  // Register addresses
  // ****************************************
  localparam logic [3:0] PAGE_RESULT = 4'h0;
  localparam logic [3:0] PAGE_CTRL = 4'h1;
  localparam logic [5:0] ADDR_CONV_CTRL = 6'h00;
  localparam logic [5:0] ADDR_DAC_CTRL = 6'h02;
  localparam logic [5:0] ADDR_RESULT_BASE = 6'h00;
  localparam int NUM_RESULTS = 10;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int POS_MODE = 15;
  localparam int POS_STOP = 14;
  localparam int POS_FUNC = 10;
  localparam int POS_RES = 8;
  localparam int POS_AVG = 6;
  localparam int POS_CLK = 4;
  localparam int POS_SETTLE = 1;
  localparam int POS_DAC_PD = 15;

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [3:0] FUNC_RST = 4'h0;
  localparam logic [1:0] RES_RST = 2'h0;
  localparam logic [1:0] AVG_RST = 2'h0;
  localparam logic [1:0] CLK_RST = 2'h0;
  localparam logic [2:0] SETTLE_RST = 3'h0;
  localparam logic MODE_RST = 1'b0;
  localparam logic DAC_PD_RST = 1'b1;

  // ****************************************
  // Function codes
  // ****************************************
  localparam logic [3:0] FN_INVALID = 4'h0;
  localparam logic [3:0] FN_SCAN_XY = 4'h1;
  localparam logic [3:0] FN_SCAN_XYZ = 4'h2;
  localparam logic [3:0] FN_X = 4'h3;
  localparam logic [3:0] FN_Y = 4'h4;
  localparam logic [3:0] FN_Z = 4'h5;
  localparam logic [3:0] FN_BATTERY_ONE_RESULT = 4'h6;
  localparam logic [3:0] FN_BATTERY_TWO_RESULT = 4'h7;
  localparam logic [3:0] FN_AUXILIARY_ONE_RESULT = 4'h8;
  localparam logic [3:0] FN_AUXILIARY_TWO_RESULT = 4'h9;
  localparam logic [3:0] FN_TEMP1 = 4'ha;
  localparam logic [3:0] FN_PORT_SCAN = 4'hb;
  localparam logic [3:0] FN_TEMP2 = 4'hc;
  localparam logic [3:0] FN_DRV_X = 4'hd;
  localparam logic [3:0] FN_DRV_Y = 4'he;
  localparam logic [3:0] FN_DRV_YX = 4'hf;

  // ****************************************
  // Result slots, also the channel codes
  // ****************************************
  localparam logic [3:0] CH_X = 4'h0;
  localparam logic [3:0] CH_Y = 4'h1;
  localparam logic [3:0] CH_PRESSURE_A = 4'h2;
  localparam logic [3:0] CH_PRESSURE_B = 4'h3;
  localparam logic [3:0] CH_BATTERY_ONE_RESULT = 4'h4;
  localparam logic [3:0] CH_BATTERY_TWO_RESULT = 4'h5;
  localparam logic [3:0] CH_AUXILIARY_ONE_RESULT = 4'h6;
  localparam logic [3:0] CH_AUXILIARY_TWO_RESULT = 4'h7;
  localparam logic [3:0] CH_TEMP1 = 4'h8;
  localparam logic [3:0] CH_TEMP2 = 4'h9;

  // Panel driver bits: {x_plus, x_minus, y_plus, y_minus}
  localparam logic [3:0] DRV_X = 4'hc;
  localparam logic [3:0] DRV_Y = 4'h3;
  localparam logic [3:0] DRV_YX = 4'h6;

  // ****************************************
  // States
  // ****************************************
  typedef enum logic [5:0] {
    ST_IDLE = 6'h01,
    ST_WAIT_PEN = 6'h02,
    ST_SETTLE = 6'h04,
    ST_CONVERT = 6'h08,
    ST_WAIT_DONE = 6'h10,
    ST_STORE = 6'h20
  } conv_state_t;

  // ****************************************
  // Timing
  // ****************************************
  localparam int CORE_CLK_MHZ = 100;
  localparam int SETTLE_T1_US = 100;
  localparam int SETTLE_T2_US = 500;
  localparam int SETTLE_T3_US = 1000;
  localparam int SETTLE_T4_US = 5000;
  localparam int SETTLE_T5_US = 10000;
  localparam int SETTLE_T6_US = 50000;
  localparam int SETTLE_T7_US = 100000;
  localparam int SETTLE_T1_CYC = SETTLE_T1_US * CORE_CLK_MHZ;
  localparam int SETTLE_T2_CYC = SETTLE_T2_US * CORE_CLK_MHZ;
  localparam int SETTLE_T3_CYC = SETTLE_T3_US * CORE_CLK_MHZ;
  localparam int SETTLE_T4_CYC = SETTLE_T4_US * CORE_CLK_MHZ;
  localparam int SETTLE_T5_CYC = SETTLE_T5_US * CORE_CLK_MHZ;
  localparam int SETTLE_T6_CYC = SETTLE_T6_US * CORE_CLK_MHZ;
  localparam int SETTLE_T7_CYC = SETTLE_T7_US * CORE_CLK_MHZ;
  localparam int CONV_CLK0_KHZ = 8000;
  localparam int CONV_CLK1_KHZ = 4000;
  localparam int CONV_CLK2_KHZ = 2000;
  localparam int CONV_CLK3_KHZ = 1000;
  localparam int CONV_HALF0_CYC = (CORE_CLK_MHZ * 1000) / (2 * CONV_CLK0_KHZ);
  localparam int CONV_HALF1_CYC = (CORE_CLK_MHZ * 1000) / (2 * CONV_CLK1_KHZ);
  localparam int CONV_HALF2_CYC = (CORE_CLK_MHZ * 1000) / (2 * CONV_CLK2_KHZ);
  localparam int CONV_HALF3_CYC = (CORE_CLK_MHZ * 1000) / (2 * CONV_CLK3_KHZ);

endpackage

/* touch_adc_function_control.sv */
/*
  Function control for the shared successive-approximation converter of a
  touch-screen interface, with the contrast DAC power-down bit.
  Assumes the serial host port is decoded elsewhere into the register
  strobes below, and that the converter macro runs on core_clk.
*/
`timescale 1ns/100ps

module touch_adc_function_control #(
  parameter int unsigned SETTLE_CYC_1 = touch_adc_pkg::SETTLE_T1_CYC,
  parameter int unsigned SETTLE_CYC_2 = touch_adc_pkg::SETTLE_T2_CYC,
  parameter int unsigned SETTLE_CYC_3 = touch_adc_pkg::SETTLE_T3_CYC,
  parameter int unsigned SETTLE_CYC_4 = touch_adc_pkg::SETTLE_T4_CYC,
  parameter int unsigned SETTLE_CYC_5 = touch_adc_pkg::SETTLE_T5_CYC,
  parameter int unsigned SETTLE_CYC_6 = touch_adc_pkg::SETTLE_T6_CYC,
  parameter int unsigned SETTLE_CYC_7 = touch_adc_pkg::SETTLE_T7_CYC
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic srst,
  // Register strobes from the serial host port
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [3:0] reg_page,
  input wire logic [5:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  output logic [15:0] reg_rdata_r,
  output logic reg_rvalid_r,
  // Touch detect pin
  input wire logic pen_down,
  // Converter macro
  output logic adc_power_r,
  output logic adc_start_r,
  output logic [3:0] adc_chan_r,
  output logic [1:0] adc_res_r,
  output logic conv_clk_r,
  input wire logic adc_done,
  input wire logic [11:0] adc_data,
  // Panel drivers {x_plus, x_minus, y_plus, y_minus}
  output logic [3:0] panel_drv_r,
  // Status pin, high when idle
  output logic result_ready_out_r,
  // Contrast DAC
  output logic dac_powerdown_r,
  output logic contrast_analog_en_r
);

  // ****************************************
  // Decoding functions
  // ****************************************
  function automatic logic [2:0] seq_len(input logic [3:0] fn);
    case (fn)
      touch_adc_pkg::FN_SCAN_XY: seq_len = 3'd2;
      touch_adc_pkg::FN_SCAN_XYZ: seq_len = 3'd4;
      touch_adc_pkg::FN_Z: seq_len = 3'd2;
      touch_adc_pkg::FN_PORT_SCAN: seq_len = 3'd4;
      touch_adc_pkg::FN_X, touch_adc_pkg::FN_Y, touch_adc_pkg::FN_BATTERY_ONE_RESULT,
      touch_adc_pkg::FN_BATTERY_TWO_RESULT, touch_adc_pkg::FN_AUXILIARY_ONE_RESULT,
      touch_adc_pkg::FN_AUXILIARY_TWO_RESULT, touch_adc_pkg::FN_TEMP1,
      touch_adc_pkg::FN_TEMP2: seq_len = 3'd1;
      default: seq_len = 3'd0;
    endcase
  endfunction

  function automatic logic [3:0] seq_chan(input logic [3:0] fn,
                                          input logic [1:0] step);
    case (fn)
      touch_adc_pkg::FN_SCAN_XY,
      touch_adc_pkg::FN_SCAN_XYZ: seq_chan = {2'h0, step};
      touch_adc_pkg::FN_X: seq_chan = touch_adc_pkg::CH_X;
      touch_adc_pkg::FN_Y: seq_chan = touch_adc_pkg::CH_Y;
      touch_adc_pkg::FN_Z:
        seq_chan = touch_adc_pkg::CH_PRESSURE_A + {3'h0, step[0]};
      touch_adc_pkg::FN_BATTERY_ONE_RESULT: seq_chan = touch_adc_pkg::CH_BATTERY_ONE_RESULT;
      touch_adc_pkg::FN_BATTERY_TWO_RESULT: seq_chan = touch_adc_pkg::CH_BATTERY_TWO_RESULT;
      touch_adc_pkg::FN_AUXILIARY_ONE_RESULT: seq_chan = touch_adc_pkg::CH_AUXILIARY_ONE_RESULT;
      touch_adc_pkg::FN_AUXILIARY_TWO_RESULT: seq_chan = touch_adc_pkg::CH_AUXILIARY_TWO_RESULT;
      touch_adc_pkg::FN_TEMP1: seq_chan = touch_adc_pkg::CH_TEMP1;
      touch_adc_pkg::FN_TEMP2: seq_chan = touch_adc_pkg::CH_TEMP2;
      touch_adc_pkg::FN_PORT_SCAN:
        seq_chan = touch_adc_pkg::CH_BATTERY_ONE_RESULT + {2'h0, step};
      touch_adc_pkg::FN_DRV_X: seq_chan = touch_adc_pkg::CH_X;
      touch_adc_pkg::FN_DRV_Y: seq_chan = touch_adc_pkg::CH_Y;
      touch_adc_pkg::FN_DRV_YX: seq_chan = touch_adc_pkg::CH_PRESSURE_A;
      default: seq_chan = touch_adc_pkg::CH_X;
    endcase
  endfunction

  // Pressure channels drive Y+ against X-
  function automatic logic [3:0] drivers_for(input logic [3:0] ch);
    case (ch)
      touch_adc_pkg::CH_X: drivers_for = touch_adc_pkg::DRV_X;
      touch_adc_pkg::CH_Y: drivers_for = touch_adc_pkg::DRV_Y;
      touch_adc_pkg::CH_PRESSURE_A,
      touch_adc_pkg::CH_PRESSURE_B: drivers_for = touch_adc_pkg::DRV_YX;
      default: drivers_for = 4'h0;
    endcase
  endfunction

  function automatic logic is_touch(input logic [3:0] fn);
    is_touch = (fn >= touch_adc_pkg::FN_SCAN_XY) &&
               (fn <= touch_adc_pkg::FN_Z);
  endfunction

  // ****************************************
  // Declarations
  // ****************************************
  touch_adc_pkg::conv_state_t state_r, state_nxt;
  logic pen_meta_r, pen_sync_r;
  logic mode_r;
  logic [3:0] func_r;
  logic [1:0] res_r, avg_r, clk_sel_r;
  logic [2:0] settle_sel_r;
  logic drive_only_r;
  logic [1:0] step_r;
  logic [3:0] avg_cnt_r;
  logic [15:0] sum_r;
  logic [23:0] settle_cnt_r;
  logic [23:0] settle_limit;
  logic [5:0] half_cnt_r;
  logic [5:0] half_limit;
  logic [11:0] result_r [touch_adc_pkg::NUM_RESULTS];
  logic conv_wr, dac_wr;
  logic [3:0] wr_func;
  logic [3:0] chan_cur;
  logic seq_last, avg_last, settle_done;
  logic [3:0] avg_last_cnt;
  logic [11:0] avg_val;

  assign conv_wr = reg_wr && reg_page == touch_adc_pkg::PAGE_CTRL &&
                   reg_addr == touch_adc_pkg::ADDR_CONV_CTRL;
  assign dac_wr = reg_wr && reg_page == touch_adc_pkg::PAGE_CTRL &&
                  reg_addr == touch_adc_pkg::ADDR_DAC_CTRL;
  assign wr_func = reg_wdata[touch_adc_pkg::POS_FUNC +: 4];
  assign chan_cur = seq_chan(func_r, step_r);
  assign seq_last = {1'b0, step_r} == (seq_len(func_r) - 3'd1);

  // ****************************************
  // Pen input synchroniser
  // ****************************************
  always_ff @(posedge core_clk) begin
    if (srst) begin
      pen_meta_r <= 1'b0;
      pen_sync_r <= 1'b0;
    end else begin
      pen_meta_r <= pen_down;
      pen_sync_r <= pen_meta_r;
    end
  end

  // ****************************************
  // Control fields
  // ****************************************
  always_ff @(posedge core_clk) begin
    if (srst) begin
      mode_r <= touch_adc_pkg::MODE_RST;
      func_r <= touch_adc_pkg::FUNC_RST;
      res_r <= touch_adc_pkg::RES_RST;
      avg_r <= touch_adc_pkg::AVG_RST;
      clk_sel_r <= touch_adc_pkg::CLK_RST;
      settle_sel_r <= touch_adc_pkg::SETTLE_RST;
      drive_only_r <= 1'b0;
    end else if (conv_wr) begin
      mode_r <= reg_wdata[touch_adc_pkg::POS_MODE];
      func_r <= wr_func;
      res_r <= reg_wdata[touch_adc_pkg::POS_RES +: 2];
      avg_r <= reg_wdata[touch_adc_pkg::POS_AVG +: 2];
      clk_sel_r <= reg_wdata[touch_adc_pkg::POS_CLK +: 2];
      settle_sel_r <= reg_wdata[touch_adc_pkg::POS_SETTLE +: 3];
      drive_only_r <= !reg_wdata[touch_adc_pkg::POS_STOP] &&
                      wr_func >= touch_adc_pkg::FN_DRV_X;
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      dac_powerdown_r <= touch_adc_pkg::DAC_PD_RST;
      contrast_analog_en_r <= !touch_adc_pkg::DAC_PD_RST;
    end else if (dac_wr) begin
      dac_powerdown_r <= reg_wdata[touch_adc_pkg::POS_DAC_PD];
      contrast_analog_en_r <= !reg_wdata[touch_adc_pkg::POS_DAC_PD];
    end
  end

  // ****************************************
  // Sequencer
  // ****************************************
  always_comb begin
    case (settle_sel_r)
      3'd1: settle_limit = 24'(SETTLE_CYC_1);
      3'd2: settle_limit = 24'(SETTLE_CYC_2);
      3'd3: settle_limit = 24'(SETTLE_CYC_3);
      3'd4: settle_limit = 24'(SETTLE_CYC_4);
      3'd5: settle_limit = 24'(SETTLE_CYC_5);
      3'd6: settle_limit = 24'(SETTLE_CYC_6);
      3'd7: settle_limit = 24'(SETTLE_CYC_7);
      default: settle_limit = 24'h000000;
    endcase
    // Non-panel inputs have no driver to settle
    if (drivers_for(chan_cur) == 4'h0) begin
      settle_limit = 24'h000000;
    end
  end

  assign settle_done = settle_cnt_r >= settle_limit;

  always_comb begin
    case (avg_r)
      2'd1: avg_last_cnt = 4'd3;
      2'd2: avg_last_cnt = 4'd7;
      2'd3: avg_last_cnt = 4'd15;
      default: avg_last_cnt = 4'd0;
    endcase
  end

  assign avg_last = avg_cnt_r == avg_last_cnt;

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      touch_adc_pkg::ST_IDLE: begin
        state_nxt = touch_adc_pkg::ST_IDLE;
      end
      touch_adc_pkg::ST_WAIT_PEN: begin
        if (pen_sync_r) begin
          state_nxt = touch_adc_pkg::ST_SETTLE;
        end
      end
      touch_adc_pkg::ST_SETTLE: begin
        if (settle_done) begin
          state_nxt = touch_adc_pkg::ST_CONVERT;
        end
      end
      touch_adc_pkg::ST_CONVERT: begin
        state_nxt = touch_adc_pkg::ST_WAIT_DONE;
      end
      touch_adc_pkg::ST_WAIT_DONE: begin
        if (adc_done) begin
          state_nxt = avg_last ? touch_adc_pkg::ST_STORE :
                                 touch_adc_pkg::ST_CONVERT;
        end
      end
      touch_adc_pkg::ST_STORE: begin
        if (!seq_last) begin
          state_nxt = touch_adc_pkg::ST_SETTLE;
        end else if (func_r <= touch_adc_pkg::FN_SCAN_XYZ && pen_sync_r) begin
          state_nxt = touch_adc_pkg::ST_SETTLE;
        end else begin
          state_nxt = touch_adc_pkg::ST_IDLE;
        end
      end
      default: state_nxt = touch_adc_pkg::ST_IDLE;
    endcase
    // A write restarts the sequence; stop or a no-conversion code idles
    if (conv_wr) begin
      if (reg_wdata[touch_adc_pkg::POS_STOP] || seq_len(wr_func) == 3'd0) begin
        state_nxt = touch_adc_pkg::ST_IDLE;
      end else if (is_touch(wr_func) && reg_wdata[touch_adc_pkg::POS_MODE]) begin
        state_nxt = touch_adc_pkg::ST_WAIT_PEN;
      end else begin
        state_nxt = touch_adc_pkg::ST_SETTLE;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      state_r <= touch_adc_pkg::ST_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst || conv_wr || state_r != touch_adc_pkg::ST_SETTLE) begin
      settle_cnt_r <= 24'h000000;
    end else if (!settle_done) begin
      settle_cnt_r <= settle_cnt_r + 24'h000001;
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst || conv_wr) begin
      step_r <= 2'h0;
    end else if (state_r == touch_adc_pkg::ST_STORE) begin
      step_r <= seq_last ? 2'h0 : step_r + 2'h1;
    end
  end

  // ****************************************
  // Averaging and result store
  // ****************************************
  always_ff @(posedge core_clk) begin
    if (srst || conv_wr || state_r == touch_adc_pkg::ST_STORE) begin
      avg_cnt_r <= 4'h0;
      sum_r <= 16'h0000;
    end else if (state_r == touch_adc_pkg::ST_WAIT_DONE && adc_done) begin
      avg_cnt_r <= avg_cnt_r + 4'h1;
      sum_r <= sum_r + {4'h0, adc_data};
    end
  end

  // Mean by shift; 16 twelve-bit samples just fit in 16 bits
  always_comb begin
    case (avg_r)
      2'd1: avg_val = 12'(sum_r >> 2);
      2'd2: avg_val = 12'(sum_r >> 3);
      2'd3: avg_val = 12'(sum_r >> 4);
      default: avg_val = sum_r[11:0];
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      for (int i = 0; i < touch_adc_pkg::NUM_RESULTS; i++) begin
        result_r[i] <= 12'h000;
      end
    end else if (state_r == touch_adc_pkg::ST_STORE && !conv_wr) begin
      result_r[chan_cur] <= avg_val;
    end
  end

  // ****************************************
  // Converter and panel outputs
  // ****************************************
  always_ff @(posedge core_clk) begin
    if (srst) begin
      adc_power_r <= 1'b0;
      adc_start_r <= 1'b0;
      adc_chan_r <= touch_adc_pkg::CH_X;
      adc_res_r <= touch_adc_pkg::RES_RST;
      result_ready_out_r <= 1'b1;
      panel_drv_r <= 4'h0;
    end else begin
      adc_power_r <= state_nxt != touch_adc_pkg::ST_IDLE;
      adc_start_r <= state_nxt == touch_adc_pkg::ST_CONVERT;
      adc_chan_r <= chan_cur;
      adc_res_r <= res_r;
      result_ready_out_r <= state_nxt == touch_adc_pkg::ST_IDLE;
      if (state_r == touch_adc_pkg::ST_SETTLE ||
          state_r == touch_adc_pkg::ST_CONVERT ||
          state_r == touch_adc_pkg::ST_WAIT_DONE) begin
        panel_drv_r <= drivers_for(chan_cur);
      end else if (state_r == touch_adc_pkg::ST_IDLE && drive_only_r) begin
        panel_drv_r <= drivers_for(chan_cur);
      end else begin
        panel_drv_r <= 4'h0;
      end
    end
  end

  // Divider rounds down: 8 MHz comes out near 8.3 MHz
  always_comb begin
    case (clk_sel_r)
      2'd1: half_limit = 6'(touch_adc_pkg::CONV_HALF1_CYC);
      2'd2: half_limit = 6'(touch_adc_pkg::CONV_HALF2_CYC);
      2'd3: half_limit = 6'(touch_adc_pkg::CONV_HALF3_CYC);
      default: half_limit = 6'(touch_adc_pkg::CONV_HALF0_CYC);
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (srst || !adc_power_r) begin
      half_cnt_r <= 6'h00;
      conv_clk_r <= 1'b0;
    end else if (half_cnt_r >= half_limit - 6'h01) begin
      half_cnt_r <= 6'h00;
      conv_clk_r <= !conv_clk_r;
    end else begin
      half_cnt_r <= half_cnt_r + 6'h01;
    end
  end

  // ****************************************
  // Register read
  // ****************************************
  always_ff @(posedge core_clk) begin
    if (srst) begin
      reg_rdata_r <= 16'h0000;
      reg_rvalid_r <= 1'b0;
    end else begin
      reg_rvalid_r <= reg_rd;
      if (reg_rd) begin
        reg_rdata_r <= 16'h0000;
        if (reg_page == touch_adc_pkg::PAGE_CTRL &&
            reg_addr == touch_adc_pkg::ADDR_CONV_CTRL) begin
          reg_rdata_r <= {pen_sync_r, result_ready_out_r, func_r, res_r,
                          avg_r, clk_sel_r, settle_sel_r,
                          1'b0};
        end else if (reg_page == touch_adc_pkg::PAGE_CTRL &&
                     reg_addr == touch_adc_pkg::ADDR_DAC_CTRL) begin
          reg_rdata_r <= {dac_powerdown_r, 15'h0000};
        end else if (reg_page == touch_adc_pkg::PAGE_RESULT &&
                     reg_addr - touch_adc_pkg::ADDR_RESULT_BASE <
                     6'(touch_adc_pkg::NUM_RESULTS)) begin
          reg_rdata_r <= {4'h0, result_r[4'(reg_addr -
                          touch_adc_pkg::ADDR_RESULT_BASE)]};
        end
      end
    end
  end

endmodule

/* touch_adc_function_control_assertions.sv */
/* Port checker for the touch converter function control.
   Assumes binding to the top module; default clocking on core_clk. */
`timescale 1ns/100ps
module touch_adc_checker (
  // Clock and reset
  input wire logic core_clk,
  input wire logic srst,
  // Watched ports
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [3:0] reg_page,
  input wire logic [5:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic [15:0] reg_rdata_r,
  input wire logic reg_rvalid_r,
  input wire logic adc_power_r,
  input wire logic adc_start_r,
  input wire logic [3:0] panel_drv_r,
  input wire logic result_ready_out_r,
  input wire logic dac_powerdown_r,
  input wire logic contrast_analog_en_r
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (srst);
  sequence ctrl_wr;
    reg_wr && reg_page == 4'h1 && reg_addr == 6'h00;
  endsequence
  sequence drv_quiet;
    (!adc_start_r && result_ready_out_r)[*3];
  endsequence
  chk_read_answer: assert property (reg_rd |=> reg_rvalid_r)
    else $error("read not answered next cycle");
  chk_bit0_zero: assert property (reg_rd && reg_page == 4'h1 &&
    reg_addr == 6'h00 |=> !reg_rdata_r[0])
    else $error("reserved bit read as one");
  chk_dac_write: assert property (reg_wr && reg_page == 4'h1 &&
    reg_addr == 6'h02 |=> dac_powerdown_r == $past(reg_wdata[15]))
    else $error("dac power-down bit not taken");
  chk_dac_float: assert property (
    contrast_analog_en_r != dac_powerdown_r)
    else $error("dac output enabled while powered down");
  chk_stop_halts: assert property (ctrl_wr ##0 reg_wdata[14]
    |=> !adc_power_r && !adc_start_r)
    else $error("stop did not halt converter");
  chk_invalid_idle: assert property (
    ctrl_wr ##0 reg_wdata[13:10] == 4'h0 |=> (!adc_power_r)[*4])
    else $error("invalid code powered converter");
  chk_drive_only: assert property (
    ctrl_wr ##0 reg_wdata[14:10] == 5'h0d
    |=> drv_quiet ##1 panel_drv_r == touch_adc_pkg::DRV_X)
    else $error("drive code misbehaved");
  chk_bat_start: assert property (
    ctrl_wr ##0 reg_wdata[14:10] == 5'h06 |-> ##2 adc_start_r)
    else $error("battery conversion start late");
  chk_start_busy: assert property (adc_start_r
    |-> !result_ready_out_r && adc_power_r)
    else $error("start while reported idle");
endmodule
bind touch_adc_function_control touch_adc_checker u_chk (
  .core_clk(core_clk), .srst(srst), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_page(reg_page), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_rdata_r(reg_rdata_r), .reg_rvalid_r(reg_rvalid_r),
  .adc_power_r(adc_power_r), .adc_start_r(adc_start_r),
  .panel_drv_r(panel_drv_r), .result_ready_out_r(result_ready_out_r),
  .dac_powerdown_r(dac_powerdown_r),
  .contrast_analog_en_r(contrast_analog_en_r));

/* adc_macro_model.sv */
/* Converter macro model: answers each start after lat cycles.
   Assumes start is a one-cycle pulse on clk. */
`timescale 1ns/100ps
module adc_macro_model (
  // Clock
  input wire logic clk,
  // Request and answer
  input wire logic start,
  input wire logic [11:0] sample,
  input wire logic [3:0] lat,
  output logic done,
  output logic [11:0] data
);
  logic [11:0] v;
  initial begin
    done = 1'b0;
    data = 12'h000;
    forever begin
      @(posedge clk);
      if (start) begin
        v = sample;
        repeat (lat) @(posedge clk);
        done <= 1'b1;
        data <= v;
        @(posedge clk);
        done <= 1'b0;
        // Stale data inverted so nobody relies on it
        data <= ~v;
      end
    end
  end
endmodule

/* touch_adc_function_control_bench.sv */
/* Self-checking bench for the touch converter function control.
   Assumes the converter macro model and the bound checker. */
`timescale 1ns/100ps
module touch_adc_function_control_bench;
  logic core_clk = 1'b0, srst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
  logic [3:0] reg_page = 4'h0, lat = 4'h1, panel_drv_r, adc_chan_r;
  logic [5:0] reg_addr = 6'h00;
  logic [15:0] reg_wdata = 16'h0000, reg_rdata_r, v;
  logic reg_rvalid_r, pen_down = 1'b0, adc_power_r, adc_start_r, conv_clk_r;
  logic adc_done, result_ready_out_r, dac_powerdown_r, contrast_analog_en_r;
  logic [1:0] adc_res_r;
  logic [11:0] adc_data, sample = 12'h000;
  int seed = 32'h3e0b, n_mismatch = 0, tests_run = 0, exp_res[10], q[$], k;
  logic cc;
  // Result slots per code, one nibble each, slot plus one
  logic [15:0] slot_tbl[16] = '{16'h0, 16'h21, 16'h4321, 16'h1, 16'h2,
    16'h43, 16'h5, 16'h6, 16'h7, 16'h8, 16'h9, 16'h8765, 16'ha, 16'h0,
    16'h0, 16'h0};
  always #5 core_clk = ~core_clk;
  // Short settle counts keep the run brief
  touch_adc_function_control #(.SETTLE_CYC_1(20), .SETTLE_CYC_2(40),
    .SETTLE_CYC_3(60)) dut (.core_clk(core_clk),
    .srst(srst), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_page(reg_page),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata_r(reg_rdata_r),
    .reg_rvalid_r(reg_rvalid_r), .pen_down(pen_down),
    .adc_power_r(adc_power_r), .adc_start_r(adc_start_r),
    .adc_chan_r(adc_chan_r), .adc_res_r(adc_res_r), .conv_clk_r(conv_clk_r),
    .adc_done(adc_done), .adc_data(adc_data), .panel_drv_r(panel_drv_r),
    .result_ready_out_r(result_ready_out_r),
    .dac_powerdown_r(dac_powerdown_r),
    .contrast_analog_en_r(contrast_analog_en_r));
  adc_macro_model model (.clk(core_clk), .start(adc_start_r),
    .sample(sample), .lat(lat), .done(adc_done), .data(adc_data));
  always @(posedge core_clk) if (adc_start_r) begin
    q.push_back(sample);
    sample <= 12'($random(seed));
  end
  task chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    tests_run++;
    if (g !== e) begin
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
      n_mismatch++;
    end
  endtask
  task wr(input logic [3:0] p, input logic [5:0] a, input logic [15:0] d);
    @(posedge core_clk);
    reg_wr <= 1'b1;
    reg_page <= p;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask
  task rd(input logic [3:0] p, input logic [5:0] a);
    @(posedge core_clk);
    reg_rd <= 1'b1;
    reg_page <= p;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 v = reg_rdata_r;
  endtask
  task chk_slots;
    for (int i = 0; i < 10; i++) begin
      rd(4'h0, 6'(i));
      chk("result slot", 16'(exp_res[i]), v);
    end
  endtask
  task give_verdict;
    $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task run(input logic [3:0] f);
    logic [15:0] w, t;
    int n, ns, sum;
    // Clock field kept at 2 or 1 MHz, legal for every resolution
    w = {2'b00, f, 2'($random(seed)), 2'($random(seed)), 1'b1,
      1'($random(seed)), 1'b0, 2'($random(seed)), 1'b0};
    ns = (w[7:6] == 2'b00) ? 1 : (2 << w[7:6]);
    lat <= 4'(3'($random(seed))) + 4'h1;
    q.delete();
    wr(4'h1, 6'h00, w);
    n = 0;
    do begin @(posedge core_clk); #1 n++; end
    while (adc_start_r !== 1'b1 && n < 400);
    chk("start delay", 16'(1 + ((f < 6) ? 20 * w[2:1] : 0)), 16'(n));
    chk("channel", 16'(slot_tbl[f][3:0] - 4'h1), 16'(adc_chan_r));
    chk("resolution", 16'(w[9:8]), 16'(adc_res_r));
    n = 0;
    while (result_ready_out_r !== 1'b1 && n < 5000) begin
      @(posedge core_clk); #1 n++;
    end
    chk("finish", 16'h1, 16'(result_ready_out_r));
    t = slot_tbl[f];
    while (t != 16'h0) begin
      sum = 0;
      repeat (ns) sum += q.pop_front();
      exp_res[t[3:0] - 1] = sum / ns;
      t = t >> 4;
    end
    chk("left samples", 16'h0, 16'(q.size()));
    chk_slots;
    $display("code %0d done", f);
  endtask
  initial begin
    #500000 n_mismatch++;
    give_verdict;
  end
  initial begin
    repeat (4) @(posedge core_clk);
    srst <= 1'b0;
    rd(4'h1, 6'h00);
    chk("ctrl reset", 16'h4000, v);
    rd(4'h1, 6'h02);
    chk("dac reset", 16'h8000, v);
    chk_slots;
    wr(4'h1, 6'h02, 16'h0000);
    rd(4'h1, 6'h02);
    chk("dac on", 16'h1, {v[15], 14'h0, contrast_analog_en_r});
    wr(4'h1, 6'h02, 16'hffff);
    rd(4'h1, 6'h02);
    chk("dac off", 16'h8000, {v[15:1], contrast_analog_en_r});
    repeat (4) begin
      w_rb: begin
        wr(4'h1, 6'h00, 16'($random(seed)) & 16'h3fff | 16'h4000);
        rd(4'h1, 6'h00);
        chk("readback", reg_wdata & 16'h7ffe | 16'h4000, v);
      end
    end
    for (int f = 1; f < 13; f++) run(4'(f));
    rd(4'h3, 6'h3f);
    chk("unmapped", 16'h0, v);
    wr(4'h1, 6'h00, 16'h0000);
    chk_slots;
    for (int f = 13; f < 16; f++) begin
      wr(4'h1, 6'h00, 16'(f) << 10);
      repeat (4) @(posedge core_clk);
      #1 chk("drivers", (f == 13) ? 16'hc : (f == 14) ? 16'h3 : 16'h6,
        16'(panel_drv_r));
    end
    wr(4'h1, 6'h00, 16'h8400);
    repeat (8) @(posedge core_clk);
    #1 chk("pen wait", 16'h0, 16'({adc_start_r, panel_drv_r}));
    @(posedge core_clk) pen_down <= 1'b1;
    k = 0;
    #1 cc = conv_clk_r;
    repeat (60) begin
      @(posedge core_clk);
      #1 k += (conv_clk_r != cc);
      cc = conv_clk_r;
    end
    chk("clock edges", 16'(60 / touch_adc_pkg::CONV_HALF0_CYC),
      16'(k));
    #1 chk("scan busy", 16'h0, 16'(result_ready_out_r));
    wr(4'h1, 6'h00, 16'h4000);
    repeat (2) @(posedge core_clk);
    #1 chk("stopped", 16'h1, {adc_power_r, result_ready_out_r});
    rd(4'h1, 6'h00);
    chk("pen seen", 16'h1, 16'(v[15]));
    give_verdict;
  end
endmodule
